// *** rtl/phy_cmd_defs.svh ***
// Purpose: offsets, field positions and timing for the custom PHY writer
// Assumes: register indices are word indices; byte address is index * 4
// Notes: definitions only
`ifndef PHY_CMD_DEFS_SVH
`define PHY_CMD_DEFS_SVH
`define IDX_CTRL_G0 10'h28b
`define IDX_CTRL_G1 10'h28c
`define IDX_CTRL_G2 10'h28d
`define IDX_CTRL_G3 10'h28e
`define IDX_DATA_BASE 10'h28f
`define IDX_DATA_LAST 10'h296
`define IDX_ENABLE 10'h297
`define IDX_RUN 10'h298
`define RESET_WORD 16'h0000
`define ODD_SEL_LSB 13
`define ODD_REG_LSB 8
`define EVEN_SEL_LSB 5
`define EVEN_REG_LSB 0
`define EN_ALL_BIT 2
`define RUN_START_BIT 0
`define RUN_BUSY_BIT 1
`define RUN_DONE_BIT 2
`define RUN_LINE_BIT 3
`define PHY_BASE_G0 5'h08
`define PHY_BASE_G1 5'h10
`define PHY_BASE_G2 5'h18
`define PHY_BASE_G3 5'h06
`define LAST_PORT_WIDE 3'h7
`define LAST_PORT_G3 3'h1
`define LAST_CMD 3'h7
`define CLK_PERIOD_NS 25
`define MDC_MIN_PERIOD_NS 400
`define MDC_HALF_NS (`MDC_MIN_PERIOD_NS / 2)
`define MDC_HALF_CYC ((`MDC_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MDIO_PREAMBLE 32'hffffffff
`define MDIO_START 2'h1
`define MDIO_OP_WRITE 2'h1
`define MDIO_TURN 2'h2
`define FRAME_LAST_BIT 6'h3f
`endif

// *** rtl/phy_cmd_pkg.sv ***
// Purpose: shared types of the custom PHY writer
// Assumes: nothing
// Notes: states are binary coded
`default_nettype none
package phy_cmd_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_CHECK = 2'h1,
    SEQ_SEND = 2'h2,
    SEQ_WAIT = 2'h3
  } seq_state_e;
endpackage
`default_nettype wire

// *** rtl/mdio_req_if.sv ***
// Purpose: carries one management write request and its completion
// Assumes: req is a one-cycle pulse, only while busy is low
// Notes: done is a one-cycle pulse at the end of the frame
`default_nettype none
interface mdio_req_if;
  logic req;
  logic [4:0] phy_addr;
  logic [4:0] reg_addr;
  logic [15:0] wdata;
  logic busy;
  logic done;
  modport requester (output req, phy_addr, reg_addr, wdata,
    input busy, done);
  modport writer (input req, phy_addr, reg_addr, wdata,
    output busy, done);
endinterface
`default_nettype wire

// *** rtl/cmd_data_mem.sv ***
// Purpose: data words of the eight commands, one write and two read ports
// Assumes: read data appear one cycle after the address
// Notes: every word resets to zero
`default_nettype none
`include "phy_cmd_defs.svh"
module cmd_data_mem (
  input wire logic clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [2:0] a_addr,
  output logic [15:0] a_rdata,
  input wire logic [2:0] b_addr,
  output logic [15:0] b_rdata
);
  logic [15:0] mem [8];
  genvar e;
  generate
    for (e = 0; e < 8; e++) begin : g_word
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          mem[e] <= `RESET_WORD;
        end else if (we && waddr == 3'(e)) begin
          mem[e] <= wdata;
        end
      end
    end
  endgenerate
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      a_rdata <= `RESET_WORD;
      b_rdata <= `RESET_WORD;
    end else begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
    end
  end
endmodule
`default_nettype wire

// *** rtl/mdio_frame_writer.sv ***
// Purpose: sends one clause 22 write frame per request
// Assumes: mdc low at rest; data change after the falling mdc edge
// Notes: write only, so the line is driven for the whole frame
`default_nettype none
`include "phy_cmd_defs.svh"
module mdio_frame_writer (
  input wire logic clk,
  input wire logic nrst,
  mdio_req_if.writer mreq,
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe
);
  localparam logic [3:0] HALF_M1 = 4'(`MDC_HALF_CYC - 1);
  logic [63:0] frame;
  logic [5:0] bit_cnt;
  logic [3:0] div;
  logic active;
  logic done_q;
  logic half_tick;
  assign half_tick = active && div == HALF_M1;
  assign mreq.busy = active;
  assign mreq.done = done_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div <= 4'h0;
    end else if (!active || half_tick) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active <= 1'h0;
      mdc <= 1'h0;
      mdio_out <= 1'h0;
      mdio_oe <= 1'h0;
      frame <= 64'h0;
      bit_cnt <= 6'h0;
      done_q <= 1'h0;
    end else begin
      done_q <= 1'h0;
      if (!active) begin
        if (mreq.req) begin
          active <= 1'h1;
          frame <= {`MDIO_PREAMBLE, `MDIO_START, `MDIO_OP_WRITE,
            mreq.phy_addr, mreq.reg_addr, `MDIO_TURN, mreq.wdata};
          mdio_out <= 1'h1;
          mdio_oe <= 1'h1;
          bit_cnt <= `FRAME_LAST_BIT;
          mdc <= 1'h0;
        end
      end else if (half_tick) begin
        mdc <= !mdc;
        // shift only after the falling edge so the phy samples stable data
        if (mdc) begin
          if (bit_cnt == 6'h0) begin
            active <= 1'h0;
            mdio_oe <= 1'h0;
            mdio_out <= 1'h0;
            done_q <= 1'h1;
          end else begin
            bit_cnt <= bit_cnt - 6'h1;
            frame <= {frame[62:0], 1'h0};
            mdio_out <= frame[62];
          end
        end
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_frame_opens: assert property (
    (mreq.req && !active) |=> mdio_oe && mdio_out && !mdc)
    else $error("frame did not open with a driven preamble bit");
  a_mdc_high_time: assert property (
    $rose(mdc) |-> mdc[*8])
    else $error("mdc high phase too short");
  a_done_quiet: assert property (
    mreq.done |-> !mdio_oe && !active)
    else $error("line still driven at frame end");
endmodule
`default_nettype wire

// *** rtl/custom_phy_command_writer.sv ***
// Purpose: issue up to eight user-defined PHY write commands, each to one port or to its whole group
// Assumes: single clock; registers on Avalon-MM with waitrequest
// Notes: byte address = register index * 4; data in bits 15:0
// What this block does
// - eight extra PHY write commands, two owned by each of four groups
// - groups: ports 0-7, 8-15, 16-23, and ports 24-25
// - each group has a three-bit enable field steering its two commands
// - every command has target selector, PHY register address and data
// - group 0 enable 010/011: command 1 to port in 15:13, PHY 0x8+n
// - group 0 enable 001/011: command 0 to port in 7:5, PHY 0x8+n
// - group 0 word: command 1 register at 12:8, command 0 at 4:0
// - group 1 enable 010/011: command 3 to port in 15:13, PHY 0x10+n
// - group 1 enable 001/011: command 2 to port in 7:5, PHY 0x10+n
// - group 1 word: command 3 register at 12:8, command 2 at 4:0
// - enable x00 nothing, 001/010 one to selected, 1xx sends each enabled command to whole group
// - group 3 selector bit: clear port 24 PHY 0x6, set port 25 PHY 0x7
//
// Implementation choice: register access over Avalon-MM.
`default_nettype none
`include "phy_cmd_defs.svh"
module custom_phy_command_writer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic mdio_in,
  output logic mdc,
  output logic mdio_out,
  output logic mdio_oe
);
  logic [1:0] bus_phase;
  logic bus_req;
  logic wr_take;
  logic [9:0] idx;
  logic [9:0] data_diff;
  logic is_data;
  logic [15:0] next_rdata;
  logic [15:0] run_status;
  logic [15:0] ctrl [4];
  logic [11:0] cmd_enable;
  logic [15:0] en_merged;
  logic [2:0] grp_en_a [4];
  logic [15:0] mem_a_rdata;
  logic [15:0] mem_b_rdata;
  logic [15:0] mem_wdata;
  logic mem_we;
  logic start_pulse;
  logic run_done;
  logic mdio_sync1;
  logic mdio_sync2;
  phy_cmd_pkg::seq_state_e state;
  logic [2:0] cmd_idx;
  logic [2:0] port_idx;
  logic [1:0] grp;
  logic odd;
  logic [15:0] ctrl_word;
  logic [2:0] en_field;
  logic cmd_on;
  logic bcast;
  logic [2:0] sel;
  logic [4:0] reg_sel;
  logic [2:0] last_port;
  logic [4:0] base;
  logic [2:0] target;
  logic [4:0] phy_sel;
  logic more_ports;
  logic advance_cmd;
  logic finishing;

  mdio_req_if mreq ();

  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    merge16 = old;
    if (be[0]) merge16[7:0] = wd[7:0];
    if (be[1]) merge16[15:8] = wd[15:8];
  endfunction

  // bus access: phase 0 sees request, phase 1 loads read data,
  // phase 2 drops waitrequest and commits a write
  assign bus_req = avs_read | avs_write;
  assign idx = avs_address[11:2];
  assign wr_take = bus_phase == 2'h2 && avs_write;
  assign data_diff = idx - `IDX_DATA_BASE;
  assign is_data = idx >= `IDX_DATA_BASE && idx <= `IDX_DATA_LAST;
  assign mem_we = wr_take && is_data;
  assign mem_wdata = merge16(mem_a_rdata, avs_writedata, avs_byteenable);
  assign en_merged = merge16({4'h0, cmd_enable}, avs_writedata,
    avs_byteenable);
  assign start_pulse = wr_take && idx == `IDX_RUN && avs_byteenable[0] &&
    avs_writedata[`RUN_START_BIT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_phase <= 2'h0;
    end else if (bus_phase == 2'h2) begin
      bus_phase <= 2'h0;
    end else if (bus_req) begin
      bus_phase <= bus_phase + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'h1;
    end else begin
      avs_waitrequest <= !(bus_phase == 2'h1 && bus_req);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0;
    end else if (bus_phase == 2'h1) begin
      avs_readdata <= {16'h0000, next_rdata};
    end
  end

  always_comb begin
    run_status = `RESET_WORD;
    run_status[`RUN_BUSY_BIT] = state != phy_cmd_pkg::SEQ_IDLE;
    run_status[`RUN_DONE_BIT] = run_done;
    run_status[`RUN_LINE_BIT] = mdio_sync2;
  end

  // unmapped indices read as zero and ignore writes
  always_comb begin
    next_rdata = `RESET_WORD;
    if (is_data) begin
      next_rdata = mem_a_rdata;
    end else begin
      case (idx)
        `IDX_CTRL_G0: next_rdata = ctrl[0];
        `IDX_CTRL_G1: next_rdata = ctrl[1];
        `IDX_CTRL_G2: next_rdata = ctrl[2];
        `IDX_CTRL_G3: next_rdata = ctrl[3];
        `IDX_ENABLE: next_rdata = {4'h0, cmd_enable};
        `IDX_RUN: next_rdata = run_status;
        default: next_rdata = `RESET_WORD;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_group
      localparam logic [9:0] MY_IDX = `IDX_CTRL_G0 + 10'(g);
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          ctrl[g] <= `RESET_WORD;
        end else if (wr_take && idx == MY_IDX) begin
          ctrl[g] <= merge16(ctrl[g], avs_writedata, avs_byteenable);
        end
      end
      assign grp_en_a[g] = cmd_enable[3*g +: 3];
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_enable <= 12'h000;
    end else if (wr_take && idx == `IDX_ENABLE) begin
      cmd_enable <= en_merged[11:0];
    end
  end

  cmd_data_mem u_data (
    .clk(clk),
    .nrst(nrst),
    .we(mem_we),
    .waddr(data_diff[2:0]),
    .wdata(mem_wdata),
    .a_addr(data_diff[2:0]),
    .a_rdata(mem_a_rdata),
    .b_addr(cmd_idx),
    .b_rdata(mem_b_rdata)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mdio_sync1 <= 1'h0;
      mdio_sync2 <= 1'h0;
    end else begin
      mdio_sync1 <= mdio_in;
      mdio_sync2 <= mdio_sync1;
    end
  end

  // command decode: cmd_idx[2:1] is the group, cmd_idx[0] picks its pair
  always_comb begin
    grp = cmd_idx[2:1];
    odd = cmd_idx[0];
    ctrl_word = ctrl[grp];
    en_field = grp_en_a[grp];
    cmd_on = en_field[odd];
    bcast = en_field[`EN_ALL_BIT];
    sel = odd ? ctrl_word[`ODD_SEL_LSB +: 3] :
      ctrl_word[`EVEN_SEL_LSB +: 3];
    reg_sel = odd ? ctrl_word[`ODD_REG_LSB +: 5] :
      ctrl_word[`EVEN_REG_LSB +: 5];
    last_port = `LAST_PORT_WIDE;
    base = `PHY_BASE_G0;
    case (grp)
      2'h0: base = `PHY_BASE_G0;
      2'h1: base = `PHY_BASE_G1;
      2'h2: base = `PHY_BASE_G2;
      2'h3: begin
        base = `PHY_BASE_G3;
        sel = {2'h0, sel[0]};
        last_port = `LAST_PORT_G3;
      end
    endcase
    target = bcast ? port_idx : sel;
    phy_sel = base + {2'h0, target};
  end

  assign more_ports = bcast && port_idx != last_port;
  assign advance_cmd = (state == phy_cmd_pkg::SEQ_CHECK && !cmd_on) ||
    (state == phy_cmd_pkg::SEQ_WAIT && mreq.done && !more_ports);
  assign finishing = advance_cmd && cmd_idx == `LAST_CMD;

  // a start while already running is ignored; walk is strictly ascending
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= phy_cmd_pkg::SEQ_IDLE;
      cmd_idx <= 3'h0;
      port_idx <= 3'h0;
    end else begin
      unique case (state)
        phy_cmd_pkg::SEQ_IDLE: begin
          if (start_pulse) begin
            state <= phy_cmd_pkg::SEQ_CHECK;
            cmd_idx <= 3'h0;
            port_idx <= 3'h0;
          end
        end
        phy_cmd_pkg::SEQ_CHECK: begin
          if (cmd_on) begin
            state <= phy_cmd_pkg::SEQ_SEND;
          end else if (finishing) begin
            state <= phy_cmd_pkg::SEQ_IDLE;
          end else begin
            cmd_idx <= cmd_idx + 3'h1;
          end
        end
        phy_cmd_pkg::SEQ_SEND: begin
          state <= phy_cmd_pkg::SEQ_WAIT;
        end
        phy_cmd_pkg::SEQ_WAIT: begin
          if (mreq.done) begin
            if (more_ports) begin
              port_idx <= port_idx + 3'h1;
              state <= phy_cmd_pkg::SEQ_SEND;
            end else if (finishing) begin
              state <= phy_cmd_pkg::SEQ_IDLE;
            end else begin
              cmd_idx <= cmd_idx + 3'h1;
              port_idx <= 3'h0;
              state <= phy_cmd_pkg::SEQ_CHECK;
            end
          end
        end
      endcase
    end
  end

  // hardware set outranks the software clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_done <= 1'h0;
    end else if (finishing) begin
      run_done <= 1'h1;
    end else if (start_pulse && state == phy_cmd_pkg::SEQ_IDLE) begin
      run_done <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mreq.req <= 1'h0;
      mreq.phy_addr <= 5'h00;
      mreq.reg_addr <= 5'h00;
      mreq.wdata <= `RESET_WORD;
    end else begin
      mreq.req <= state == phy_cmd_pkg::SEQ_SEND;
      if (state == phy_cmd_pkg::SEQ_SEND) begin
        mreq.phy_addr <= phy_sel;
        mreq.reg_addr <= reg_sel;
        mreq.wdata <= mem_b_rdata;
      end
    end
  end

  mdio_frame_writer u_mdio (
    .clk(clk),
    .nrst(nrst),
    .mreq(mreq.writer),
    .mdc(mdc),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_frame_taken;
    mreq.req ##1 mreq.busy;
  endsequence

  sequence s_bus_answer;
    avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  a_bus_answer: assert property (
    (bus_req && bus_phase == 2'h0) |-> s_bus_answer)
    else $error("bus answer not in the third cycle");
  a_start_runs: assert property (
    (state == phy_cmd_pkg::SEQ_IDLE && start_pulse) |=>
      (state == phy_cmd_pkg::SEQ_CHECK && cmd_idx == 3'h0))
    else $error("start did not begin at command 0");
  a_req_when_free: assert property (
    mreq.req |-> !mreq.busy)
    else $error("frame requested while writer busy");
  a_order_up: assert property (
    (state != phy_cmd_pkg::SEQ_IDLE &&
      $past(state) != phy_cmd_pkg::SEQ_IDLE) |->
      cmd_idx >= $past(cmd_idx))
    else $error("commands not issued in ascending order");
  a_frame_sent: assert property (
    (state == phy_cmd_pkg::SEQ_SEND) |=> s_frame_taken)
    else $error("command not handed to the frame writer");
  a_g0_target: assert property (
    (state == phy_cmd_pkg::SEQ_SEND && grp == 2'h0 && !bcast) |=>
      mreq.phy_addr == `PHY_BASE_G0 + {2'h0, $past(sel)})
    else $error("group 0 phy address wrong");
  a_g1_target: assert property (
    (state == phy_cmd_pkg::SEQ_SEND && grp == 2'h1 && !bcast) |=>
      mreq.phy_addr == `PHY_BASE_G1 + {2'h0, $past(sel)})
    else $error("group 1 phy address wrong");
  a_g3_target: assert property (
    (state == phy_cmd_pkg::SEQ_SEND && grp == 2'h3 && !bcast) |=>
      mreq.phy_addr == (ctrl[3][`ODD_SEL_LSB] && $past(odd) ||
        ctrl[3][`EVEN_SEL_LSB] && !$past(odd) ? 5'h07 : 5'h06))
    else $error("group 3 phy address wrong");
  a_g0_reg: assert property (
    (state == phy_cmd_pkg::SEQ_SEND && grp == 2'h0 && odd) |=>
      mreq.reg_addr == ctrl[0][12:8])
    else $error("group 0 command 1 register address wrong");
  a_g1_reg: assert property (
    (state == phy_cmd_pkg::SEQ_SEND && grp == 2'h1 && !odd) |=>
      mreq.reg_addr == ctrl[1][4:0])
    else $error("group 1 command 2 register address wrong");
  a_skip_off: assert property (
    (state == phy_cmd_pkg::SEQ_CHECK && !cmd_on) |=>
      state != phy_cmd_pkg::SEQ_SEND)
    else $error("disabled command was sent");
  a_port_bound: assert property (
    (state != phy_cmd_pkg::SEQ_IDLE) |-> port_idx <= last_port)
    else $error("broadcast ran past the group");
  a_eight_cmds: assert property (
    (state == phy_cmd_pkg::SEQ_CHECK && cmd_idx == 3'h7 && !cmd_on) |=>
      (state == phy_cmd_pkg::SEQ_IDLE && run_done))
    else $error("run did not end after command 7");
  a_data_carried: assert property (
    (state == phy_cmd_pkg::SEQ_SEND) |=> mreq.wdata == $past(mem_b_rdata))
    else $error("command data not carried into the frame");
endmodule
`default_nettype wire

// *** tb/phy_mgmt_model.sv ***
// Purpose: management-side PHY that records every write frame it sees
// Assumes: the PHY samples the data line on the rising mdc edge
// Notes: line has a pull-up, so it reads high when nobody drives it
`default_nettype none
module phy_mgmt_model (
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdio_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [63:0] sh = 64'h0;
  int n = 0;
  int bad = 0;
  logic [25:0] got [$];
  assign mdio_in = mdio_oe ? mdio_out : 1'b1;
  // a frame restarts whenever the writer lets go of the line
  always @(posedge mdc or negedge mdio_oe) begin
    if (!mdio_oe) begin
      n = 0;
    end else begin
      sh = {sh[62:0], mdio_out};
      n++;
      if (n == 64) begin
        if (sh[63:28] !== 36'hffffffff5 || sh[17:16] !== 2'b10) begin
          bad++;
        end
        got.push_back({sh[27:18], sh[15:0]});
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/tb_custom_phy_command_writer.sv ***
// Purpose: bench for the custom PHY command writer
// Assumes: every bus access is answered by waitrequest going low
// Notes: expected frames are built from the words written here
`default_nettype none
`include "phy_cmd_defs.svh"
module tb_custom_phy_command_writer;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h3;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  wire mdio_in;
  logic mdc;
  logic mdio_out;
  logic mdio_oe;
  int fails = 0;
  int comparisons = 0;
  logic [15:0] ctl [4];
  logic [15:0] dat [8];
  logic [25:0] exp_q [$];
  logic [31:0] rd;

  custom_phy_command_writer u_custom_phy_command_writer (.clk, .nrst,
    .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .mdio_in, .mdc,
    .mdio_out, .mdio_oe);
  phy_mgmt_model u_phy_mgmt_model (.mdc, .mdio_out, .mdio_oe, .mdio_in);

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic final_report();
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [9:0] idx,
      input logic [15:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {16'h0, wd};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 16);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      final_report();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] wd);
    bus(1'b1, idx, wd, 4'h3);
  endtask

  task automatic rchk(input string what, input logic [9:0] idx,
      input logic [15:0] exp);
    bus(1'b0, idx, 16'h0, 4'h3);
    chk(what, {16'h0, exp}, rd);
  endtask

  task automatic expect_run(input logic [11:0] en);
    logic [2:0] e;
    logic [4:0] base;
    logic [2:0] sel;
    logic [15:0] c;
    int np;
    for (int g = 0; g < 4; g++) begin
      c = ctl[g];
      e = en[3*g +: 3];
      base = (g == 3) ? 5'h06 : 5'(8 * (g + 1));
      np = (g == 3) ? 2 : 8;
      for (int k = 0; k < 2; k++) begin
        sel = k ? c[15:13] : c[7:5];
        if (g == 3) sel = {2'b00, k ? c[13] : c[5]};
        for (int p = 0; p < np; p++) begin
          if (e[k] && (e[2] || p == int'(sel))) begin
            exp_q.push_back({base + 5'(p), k ? c[12:8] : c[4:0],
              dat[2*g+k]});
          end
        end
      end
    end
  endtask

  task automatic run(input logic [11:0] en);
    int n;
    int seen0;
    exp_q = {};
    // the model alone writes its log; each run checks only its own tail
    seen0 = u_phy_mgmt_model.got.size();
    expect_run(en);
    wr(`IDX_ENABLE, {4'h0, en});
    wr(`IDX_RUN, 16'h0001);
    bus(1'b0, `IDX_RUN, 16'h0, 4'h3);
    chk("busy", 32'h1, {31'h0, rd[1]});
    wr(`IDX_RUN, 16'h0001);
    n = 0;
    do begin
      bus(1'b0, `IDX_RUN, 16'h0, 4'h3);
      n++;
    end while (rd[2] !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      fails++;
      final_report();
    end
    // line bit trails done by the two-flop synchroniser; read once more
    bus(1'b0, `IDX_RUN, 16'h0, 4'h3);
    chk("run status", 32'h000c, rd);
    chk("frame count", exp_q.size(),
      u_phy_mgmt_model.got.size() - seen0);
    chk("frame format", 32'h0, u_phy_mgmt_model.bad);
    foreach (exp_q[i]) begin
      if (seen0 + i < u_phy_mgmt_model.got.size()) begin
        chk("frame", exp_q[i], u_phy_mgmt_model.got[seen0 + i]);
      end
    end
  endtask

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      rchk("reset", 10'(`IDX_CTRL_G0 + i), i == 13 ? 16'h8 : 16'h0);
    end
    wr(`IDX_CTRL_G2, 16'ha5c3);
    rchk("group2 ctrl", `IDX_CTRL_G2, 16'ha5c3);
    bus(1'b1, `IDX_CTRL_G2, 16'h1234, 4'h2);
    rchk("byte lane", `IDX_CTRL_G2, 16'h12c3);
    bus(1'b1, 10'h3ff, 16'hffff, 4'h3);
    rchk("unmapped", 10'h3ff, 16'h0);
    wr(`IDX_ENABLE, 16'hffff);
    rchk("enable", `IDX_ENABLE, 16'h0fff);
    for (int i = 0; i < 8; i++) begin
      dat[i] = 16'h0f0f ^ 16'(i * 16'h1357);
      wr(10'(`IDX_DATA_BASE + i), dat[i]);
      rchk("data", 10'(`IDX_DATA_BASE + i), dat[i]);
    end
    // group3 word also sets unused selector bits, which must be ignored
    ctl = '{16'hff00, 16'haab5, 16'h4c6d, 16'hc3f1};
    for (int g = 0; g < 4; g++) begin
      wr(10'(`IDX_CTRL_G0 + g), ctl[g]);
      rchk("ctrl", 10'(`IDX_CTRL_G0 + g), ctl[g]);
    end
    run(12'h60b);
    run(12'hd15);
    run(12'he7e);
    final_report();
  end
endmodule
`default_nettype wire
